/* File: rtl/pss_top.sv */
`timescale 1ns/1ps
module pss_top #(
   parameter logic [4:0] WAKE_DWELL_LOG2 = pss_pkg::WAKE_DWELL_RST
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic wake_req,
   input wire logic core_good,
   input wire logic analogue_good,
   input wire logic pll_good,
   input wire logic io_good,
   output logic core_rail_converter_en,
   output logic analogue_rail_converter_en,
   output logic pll_linear_regulator_en,
   output logic io_supply_output_en,
   output logic core_rail_pulse_frequency_modulation,
   output logic analogue_rail_pulse_frequency_modulation,
   output logic tile_clock_stop,
   output logic [2:0] state_code
);

   // Merge a write into a register through its writable mask.
   function automatic logic [31:0] merge(
      input logic [31:0] old_val,
      input logic [31:0] wr_val,
      input logic [31:0] mask
   );
      merge = (old_val & ~mask) | (wr_val & mask);
   endfunction

   // Map the internal Gray-coded state to the published state code.
   function automatic logic [2:0] code_of(input pss_pkg::pss_state_e s);
      logic [2:0] c;
      c = pss_pkg::CODE_RESET;
      case (s)
         pss_pkg::PSS_RESET: c = pss_pkg::CODE_RESET;
         pss_pkg::PSS_ASLEEP: c = pss_pkg::CODE_ASLEEP;
         pss_pkg::PSS_WAKE1: c = pss_pkg::CODE_WAKE1;
         pss_pkg::PSS_WAKE2: c = pss_pkg::CODE_WAKE2;
         pss_pkg::PSS_AWAKE_WAIT: c = pss_pkg::CODE_AWAKE_WAIT;
         pss_pkg::PSS_AWAKE: c = pss_pkg::CODE_AWAKE;
         pss_pkg::PSS_SLEEP1: c = pss_pkg::CODE_SLEEP1;
         pss_pkg::PSS_SLEEP2: c = pss_pkg::CODE_SLEEP2;
         default: c = pss_pkg::CODE_RESET;
      endcase
      code_of = c;
   endfunction

   logic [31:0] awake_supply_config_q;
   logic [31:0] sleep_stage1_supply_config_q;
   logic [31:0] sleep_stage2_supply_config_q;

   pss_pkg::pss_state_e state_q;
   pss_pkg::pss_state_e state_d;

   logic setup_ph;
   logic access_ph;
   logic wr_en;
   logic hit_awake;
   logic hit_sleep1;
   logic hit_sleep2;
   logic hit_status;
   logic hit_any;
   logic [31:0] rd_val;
   logic [31:0] status_val;

   logic [31:0] cfg_now;
   logic [31:0] cfg_next;
   logic [4:0] dwell_log2;
   logic dwell_done;
   logic supplies_good;
   logic state_change;

   // Single wait-free access: pready is raised for the access phase.
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & pready;
   assign wr_en = access_ph & pwrite;

   always_comb begin
      hit_awake = 1'b0;
      hit_sleep1 = 1'b0;
      hit_sleep2 = 1'b0;
      hit_status = 1'b0;
      if (paddr == pss_pkg::OFS_AWAKE) begin
         hit_awake = 1'b1;
      end else if (paddr == pss_pkg::OFS_SLEEP1) begin
         hit_sleep1 = 1'b1;
      end else if (paddr == pss_pkg::OFS_SLEEP2) begin
         hit_sleep2 = 1'b1;
      end else if (paddr == pss_pkg::OFS_STATUS) begin
         hit_status = 1'b1;
      end
   end

   assign hit_any = hit_awake | hit_sleep1 | hit_sleep2 | hit_status;

   // Status word: state code, dwell expiry and the four good levels.
   always_comb begin
      status_val = 32'h0000_0000;
      status_val[2:0] = code_of(state_q);
      status_val[4] = dwell_done;
      status_val[8] = core_good;
      status_val[9] = analogue_good;
      status_val[10] = pll_good;
      status_val[11] = io_good;
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_awake) begin
         rd_val = awake_supply_config_q;
      end else if (hit_sleep1) begin
         rd_val = sleep_stage1_supply_config_q;
      end else if (hit_sleep2) begin
         rd_val = sleep_stage2_supply_config_q;
      end else if (hit_status) begin
         rd_val = status_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_ph;
      end
   end

   // Read data and error are captured in setup so they come from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_val;
         pslverr <= ~hit_any;
      end else begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // Reserved bits and the analogue enable keep their reset value
   // because the write mask leaves them out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         awake_supply_config_q <= pss_pkg::RST_AWAKE;
      end else if (wr_en && hit_awake) begin
         awake_supply_config_q <= merge(awake_supply_config_q, pwdata,
                                        pss_pkg::MASK_AWAKE);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_stage1_supply_config_q <= pss_pkg::RST_SLEEP1;
      end else if (wr_en && hit_sleep1) begin
         sleep_stage1_supply_config_q <= merge(sleep_stage1_supply_config_q,
                                               pwdata,
                                               pss_pkg::MASK_SLEEP);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_stage2_supply_config_q <= pss_pkg::RST_SLEEP2;
      end else if (wr_en && hit_sleep2) begin
         sleep_stage2_supply_config_q <= merge(sleep_stage2_supply_config_q,
                                               pwdata,
                                               pss_pkg::MASK_SLEEP);
      end
   end

   // Supply settings in force for a given state.
   function automatic logic [31:0] cfg_of(
      input pss_pkg::pss_state_e s,
      input logic [31:0] awake_cfg,
      input logic [31:0] sleep1_cfg,
      input logic [31:0] sleep2_cfg
   );
      logic [31:0] c;
      c = pss_pkg::CFG_RESET;
      case (s)
         pss_pkg::PSS_AWAKE: c = awake_cfg;
         pss_pkg::PSS_SLEEP1: c = sleep1_cfg;
         pss_pkg::PSS_SLEEP2: c = sleep2_cfg;
         pss_pkg::PSS_ASLEEP: c = pss_pkg::CFG_ASLEEP;
         pss_pkg::PSS_WAKE1: c = pss_pkg::CFG_WAKE1;
         pss_pkg::PSS_WAKE2: c = pss_pkg::CFG_WAKE2;
         pss_pkg::PSS_AWAKE_WAIT: c = pss_pkg::CFG_WAKE2;
         default: c = pss_pkg::CFG_RESET;
      endcase
      cfg_of = c;
   endfunction

   assign cfg_now = cfg_of(state_q, awake_supply_config_q,
                           sleep_stage1_supply_config_q,
                           sleep_stage2_supply_config_q);
   assign cfg_next = cfg_of(state_d, awake_supply_config_q,
                            sleep_stage1_supply_config_q,
                            sleep_stage2_supply_config_q);

   // Only the sleeping stages take their stay from a register; the
   // waking stages use a fixed figure, the awake state has none.
   always_comb begin
      dwell_log2 = 5'h00;
      case (state_q)
         pss_pkg::PSS_SLEEP1: begin
            dwell_log2 = sleep_stage1_supply_config_q[
               pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W];
         end
         pss_pkg::PSS_SLEEP2: begin
            dwell_log2 = sleep_stage2_supply_config_q[
               pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W];
         end
         pss_pkg::PSS_WAKE1: begin
            dwell_log2 = WAKE_DWELL_LOG2;
         end
         pss_pkg::PSS_WAKE2: begin
            dwell_log2 = WAKE_DWELL_LOG2;
         end
         default: begin
            dwell_log2 = 5'h00;
         end
      endcase
   end

   assign state_change = (state_d != state_q);

   pss_dwell_timer pss_dwell_timer_inst (
      .pclk(pclk),
      .presetn(presetn),
      .restart(state_change),
      .log2_cycles(dwell_log2),
      .expired(dwell_done)
   );

   // A supply that is off in the current state does not hold the
   // sequence back; one that is on must report good.
   assign supplies_good =
      (~cfg_now[pss_pkg::BIT_CORE_EN] | core_good) &
      (~cfg_now[pss_pkg::BIT_ANA_EN] | analogue_good) &
      (~cfg_now[pss_pkg::BIT_PLL_EN] | pll_good) &
      (~cfg_now[pss_pkg::BIT_IO_EN] | io_good);

   always_comb begin
      state_d = state_q;
      case (state_q)
         pss_pkg::PSS_RESET: begin
            state_d = pss_pkg::PSS_AWAKE_WAIT;
         end
         pss_pkg::PSS_AWAKE_WAIT: begin
            if (supplies_good) begin
               state_d = pss_pkg::PSS_AWAKE;
            end
         end
         pss_pkg::PSS_AWAKE: begin
            if (sleep_req && supplies_good) begin
               state_d = pss_pkg::PSS_SLEEP1;
            end
         end
         pss_pkg::PSS_SLEEP1: begin
            if (dwell_done && supplies_good) begin
               state_d = pss_pkg::PSS_SLEEP2;
            end
         end
         pss_pkg::PSS_SLEEP2: begin
            if (dwell_done && supplies_good) begin
               state_d = pss_pkg::PSS_ASLEEP;
            end
         end
         pss_pkg::PSS_ASLEEP: begin
            if (wake_req) begin
               state_d = pss_pkg::PSS_WAKE1;
            end
         end
         pss_pkg::PSS_WAKE1: begin
            if (dwell_done && supplies_good) begin
               state_d = pss_pkg::PSS_WAKE2;
            end
         end
         pss_pkg::PSS_WAKE2: begin
            if (dwell_done && supplies_good) begin
               state_d = pss_pkg::PSS_AWAKE_WAIT;
            end
         end
         default: begin
            state_d = pss_pkg::PSS_RESET;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= pss_pkg::PSS_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_code <= pss_pkg::CODE_RESET;
      end else begin
         state_code <= code_of(state_d);
      end
   end

   // Outputs follow the settings of the state being entered, so a
   // register write reaches the pins one cycle after it lands while
   // its state is active, or on entry otherwise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_rail_converter_en <= pss_pkg::CFG_RESET[pss_pkg::BIT_CORE_EN];
         analogue_rail_converter_en <=
            pss_pkg::CFG_RESET[pss_pkg::BIT_ANA_EN];
         pll_linear_regulator_en <= pss_pkg::CFG_RESET[pss_pkg::BIT_PLL_EN];
         io_supply_output_en <= pss_pkg::CFG_RESET[pss_pkg::BIT_IO_EN];
      end else begin
         core_rail_converter_en <= cfg_next[pss_pkg::BIT_CORE_EN];
         analogue_rail_converter_en <= cfg_next[pss_pkg::BIT_ANA_EN];
         pll_linear_regulator_en <= cfg_next[pss_pkg::BIT_PLL_EN];
         io_supply_output_en <= cfg_next[pss_pkg::BIT_IO_EN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_rail_pulse_frequency_modulation <= 1'b0;
         analogue_rail_pulse_frequency_modulation <= 1'b0;
      end else begin
         core_rail_pulse_frequency_modulation <=
            cfg_next[pss_pkg::BIT_CORE_PFM];
         analogue_rail_pulse_frequency_modulation <=
            cfg_next[pss_pkg::BIT_ANA_PFM];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tile_clock_stop <= 1'b0;
      end else begin
         tile_clock_stop <= cfg_next[pss_pkg::BIT_TILE_STOP];
      end
   end

endmodule

/* File: include/pss_pkg.sv */
package pss_pkg;

   localparam logic [7:0] OFS_AWAKE = 8'h18;
   localparam logic [7:0] OFS_SLEEP1 = 8'h1C;
   localparam logic [7:0] OFS_SLEEP2 = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h40;

   localparam int BIT_CORE_EN = 0;
   localparam int BIT_ANA_EN = 1;
   localparam int BIT_PLL_EN = 4;
   localparam int BIT_IO_EN = 5;
   localparam int BIT_CORE_PFM = 8;
   localparam int BIT_ANA_PFM = 9;
   localparam int BIT_TILE_STOP = 14;
   localparam int DWELL_LSB = 16;
   localparam int DWELL_W = 5;

   localparam logic [31:0] MASK_AWAKE = 32'h0000_4331;
   localparam logic [31:0] MASK_SLEEP = 32'h001F_4331;
   localparam logic [31:0] RST_AWAKE = 32'h0000_0033;
   localparam logic [31:0] RST_SLEEP1 = 32'h0010_0022;
   localparam logic [31:0] RST_SLEEP2 = 32'h0010_0002;

   // Fixed supply settings for the states that have no register here.
   localparam logic [31:0] CFG_RESET = 32'h0000_0033;
   localparam logic [31:0] CFG_ASLEEP = 32'h0000_0002;
   localparam logic [31:0] CFG_WAKE1 = 32'h0000_0022;
   localparam logic [31:0] CFG_WAKE2 = 32'h0000_0033;
   localparam logic [4:0] WAKE_DWELL_RST = 5'h10;

   localparam logic [2:0] CODE_RESET = 3'h0;
   localparam logic [2:0] CODE_ASLEEP = 3'h1;
   localparam logic [2:0] CODE_WAKE1 = 3'h2;
   localparam logic [2:0] CODE_WAKE2 = 3'h3;
   localparam logic [2:0] CODE_AWAKE_WAIT = 3'h4;
   localparam logic [2:0] CODE_AWAKE = 3'h5;
   localparam logic [2:0] CODE_SLEEP1 = 3'h6;
   localparam logic [2:0] CODE_SLEEP2 = 3'h7;

   typedef enum logic [2:0] {
      PSS_RESET = 3'b000,
      PSS_AWAKE_WAIT = 3'b001,
      PSS_AWAKE = 3'b011,
      PSS_SLEEP1 = 3'b010,
      PSS_SLEEP2 = 3'b110,
      PSS_ASLEEP = 3'b111,
      PSS_WAKE1 = 3'b101,
      PSS_WAKE2 = 3'b100
   } pss_state_e;

endpackage

/* File: rtl/pss_dwell_timer.sv */
`timescale 1ns/1ps
module pss_dwell_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic [4:0] log2_cycles,
   output logic expired
);

   logic [31:0] cnt_q;
   logic [31:0] limit;

   // Counter is zero in the first cycle of a state, so expiry at
   // count 2^n - 1 gives a stay of exactly 2^n cycles.
   assign limit = 32'(({1'b0, 32'hFFFF_FFFF}) >> (6'd32 - {1'b0, log2_cycles}))
                  ;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0000_0000;
      end else if (restart) begin
         cnt_q <= 32'h0000_0000;
      end else if (cnt_q < limit) begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end

   assign expired = (cnt_q >= limit);

endmodule

/* File: dv/pss_reg_model.sv */
`timescale 1ns/1ps
// Regulators report good some cycles after being enabled, and drop good
// at once when disabled; slow stretches the rise to eight cycles.
module pss_reg_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic [3:0] en,
   output logic [3:0] good
);
   logic [3:0] sh_q [8];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) sh_q[i] <= 4'h0;
      end else begin
         sh_q[0] <= en;
         for (int i = 1; i < 8; i++) sh_q[i] <= sh_q[i-1] & en;
      end
   end
   assign good = en & (slow ? sh_q[7] : sh_q[0]);
endmodule

/* File: dv/pss_chk.sv */
`timescale 1ns/1ps
module pss_chk #(
   parameter logic [4:0] WAKE_DWELL_LOG2 = 5'h10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleep_req,
   input wire logic wake_req,
   input wire logic core_good,
   input wire logic analogue_good,
   input wire logic pll_good,
   input wire logic io_good,
   input wire logic core_rail_converter_en,
   input wire logic analogue_rail_converter_en,
   input wire logic pll_linear_regulator_en,
   input wire logic io_supply_output_en,
   input wire logic core_rail_pulse_frequency_modulation,
   input wire logic analogue_rail_pulse_frequency_modulation,
   input wire logic tile_clock_stop,
   input wire logic [2:0] state_code
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic [5:0] pins;
   assign acc = psel && penable && pready;
   assign pins = {tile_clock_stop, analogue_rail_pulse_frequency_modulation,
      core_rail_pulse_frequency_modulation, io_supply_output_en,
      pll_linear_regulator_en, core_rail_converter_en};
   sequence s_wr_awake;
      acc && pwrite && paddr == 8'h18 && state_code == 3'h5;
   endsequence
   sequence s_stay_awake;
      (state_code == 3'h5) [*2];
   endsequence
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_unmapped_err: assert property (acc && !(paddr inside
      {8'h18, 8'h1C, 8'h20, 8'h40}) |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ana_const: assert property (state_code >= 3'h5
      |-> analogue_rail_converter_en) else $error("analogue enable low");
   a_reset_pins: assert property (state_code == 3'h0 |-> pins == 6'h07)
      else $error("reset state pins wrong");
   a_awake_leave: assert property ($past(state_code) == 3'h5 &&
      state_code != 3'h5 |-> state_code == 3'h6 && $past(sleep_req))
      else $error("bad exit from awake");
   a_sleep1_leave: assert property ($past(state_code) == 3'h6 &&
      state_code != 3'h6 |-> state_code == 3'h7 &&
      $past((core_good || !core_rail_converter_en) &&
      (pll_good || !pll_linear_regulator_en) &&
      (io_good || !io_supply_output_en) && analogue_good))
      else $error("bad exit from first sleep stage");
   a_sleep2_leave: assert property ($past(state_code) == 3'h7 &&
      state_code != 3'h7 |-> state_code == 3'h1)
      else $error("bad exit from second sleep stage");
   a_write_pins: assert property (s_wr_awake ##1 s_stay_awake |->
      pins == {$past(pwdata[14], 2), $past(pwdata[9:8], 2),
      $past(pwdata[5:4], 2), $past(pwdata[0], 2)})
      else $error("awake write not on pins");
endmodule

bind pss_top pss_chk #(.WAKE_DWELL_LOG2(WAKE_DWELL_LOG2)) pss_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
   .wake_req(wake_req), .core_good(core_good),
   .analogue_good(analogue_good), .pll_good(pll_good), .io_good(io_good),
   .core_rail_converter_en(core_rail_converter_en),
   .analogue_rail_converter_en(analogue_rail_converter_en),
   .pll_linear_regulator_en(pll_linear_regulator_en),
   .io_supply_output_en(io_supply_output_en),
   .core_rail_pulse_frequency_modulation(core_rail_pulse_frequency_modulation),
   .analogue_rail_pulse_frequency_modulation(
      analogue_rail_pulse_frequency_modulation),
   .tile_clock_stop(tile_clock_stop), .state_code(state_code));

/* File: dv/test_power_state_supply_config.sv */
`timescale 1ns/1ps
module test_power_state_supply_config;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic sleep_req = 1'b0;
   logic wake_req = 1'b0;
   logic slow = 1'b0;
   logic [31:0] prdata, pins, rd;
   logic pready, pslverr, err, cen, aen, pen, ien, cpfm, apfm, tstop;
   logic [3:0] good;
   logic [2:0] state_code;
   int fails = 0;
   int n_tests = 0;
   int n;
   always #5 pclk = ~pclk;
   assign pins = {17'h0, tstop, 4'h0, apfm, cpfm, 2'h0, ien, pen, 2'h0,
      aen, cen};
   pss_top #(.WAKE_DWELL_LOG2(5'h02)) pss_top_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .wake_req(wake_req),
      .core_good(good[0]), .analogue_good(good[1]), .pll_good(good[2]),
      .io_good(good[3]), .core_rail_converter_en(cen),
      .analogue_rail_converter_en(aen), .pll_linear_regulator_en(pen),
      .io_supply_output_en(ien),
      .core_rail_pulse_frequency_modulation(cpfm),
      .analogue_rail_pulse_frequency_modulation(apfm),
      .tile_clock_stop(tstop), .state_code(state_code));
   pss_reg_model pss_reg_model_inst (.pclk(pclk), .presetn(presetn),
      .slow(slow), .en({ien, pen, aen, cen}), .good(good));
   task automatic results();
      if (fails == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1) begin
         fails++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("readback", rd, exp);
   endtask
   // Samples are taken just after an edge, so they show the settled value
   // of the cycle that the edge closed.
   task automatic wait_state(input logic [2:0] code);
      int i;
      for (i = 0; i < 300 && state_code !== code; i++) @(posedge pclk);
      if (state_code !== code) begin
         fails++;
         results();
      end
   endtask
   task automatic dwell(input logic [2:0] code);
      for (n = 0; n < 300 && state_code === code; n++) @(posedge pclk);
   endtask
   task automatic t_reset();
      rd_chk(8'h18, 32'h0000_0033);
      rd_chk(8'h1C, 32'h0010_0022);
      rd_chk(8'h20, 32'h0010_0002);
      wait_state(3'h5);
      chk("awake pins", pins, 32'h0000_0033);
      rd_chk(8'h40, 32'h0000_0F15);
   endtask
   task automatic t_awake_bits();
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      rd_chk(8'h18, 32'h0000_4333);
      chk("awake pins all", pins, 32'h0000_4333);
      apb(1'b1, 8'h18, 32'h0000_0000);
      rd_chk(8'h18, 32'h0000_0002);
      chk("awake pins none", pins, 32'h0000_0002);
      apb(1'b1, 8'h18, 32'h0000_0033);
   endtask
   task automatic t_unmapped();
      apb(1'b1, 8'h24, 32'hFFFF_FFFF);
      chk("unmapped wr err", {31'h0, err}, 32'h1);
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped rd err", {31'h0, err}, 32'h1);
      chk("unmapped rd data", rd, 32'h0);
   endtask
   // A full sleep and wake round; slow regulators lengthen the wake path.
   task automatic t_cycle(input logic slw);
      apb(1'b1, 8'h1C, 32'hFFE2_4210);
      rd_chk(8'h1C, 32'h0002_4212);
      // Stage two enables only the always-good analogue rail, so its
      // stay is the bare dwell with no wait for a rising supply.
      apb(1'b1, 8'h20, 32'h0000_0100);
      rd_chk(8'h20, 32'h0000_0102);
      slow <= slw;
      sleep_req <= 1'b1;
      wait_state(3'h6);
      sleep_req <= 1'b0;
      chk("sleep1 pins", pins, 32'h0000_4212);
      dwell(3'h6);
      chk("sleep1 dwell", n, 4);
      chk("sleep2 pins", pins, 32'h0000_0102);
      dwell(3'h7);
      chk("sleep2 dwell", n, 1);
      chk("asleep code", {29'h0, state_code}, 32'h1);
      wake_req <= 1'b1;
      wait_state(3'h2);
      wake_req <= 1'b0;
      wait_state(3'h5);
      chk("woken pins", pins, 32'h0000_0033);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_awake_bits();
      t_unmapped();
      t_cycle(1'b0);
      t_cycle(1'b1);
      results();
   end
endmodule
